// *** verilog/hbridge_defines.svh ***
// Offsets of clear bits, field positions, reset values and fault filter timing.
`ifndef HBRIDGE_DEFINES_SVH
`define HBRIDGE_DEFINES_SVH

// ****************************************************
// Clock and timing
// ****************************************************
`define CLK_PERIOD_NS      100
`define OT_FILTER_NS       11000
`define TW_FILTER_NS       11000
`define UV_FILTER_NS       10000
`define OV_FILTER_NS       3000
`define SC_FILTER_NS       1000
`define OC_FILTER_NS       1000
// All times round down to whole cycles
`define OT_FILTER_CYC      (`OT_FILTER_NS / `CLK_PERIOD_NS)
`define TW_FILTER_CYC      (`TW_FILTER_NS / `CLK_PERIOD_NS)
`define UV_FILTER_CYC      (`UV_FILTER_NS / `CLK_PERIOD_NS)
`define OV_FILTER_CYC      (`OV_FILTER_NS / `CLK_PERIOD_NS)
`define SC_FILTER_CYC      (`SC_FILTER_NS / `CLK_PERIOD_NS)
`define OC_FILTER_CYC      (`OC_FILTER_NS / `CLK_PERIOD_NS)

// ****************************************************
// Clear-fault bit positions
// ****************************************************
`define CLR_OT             0
`define CLR_OC             1
`define CLR_OL             2
`define CLR_UV             3
`define CLR_OV             4
`define CLR_SCA            5
`define CLR_SCB            6
`define CLR_W              8

// ****************************************************
// Fault-status mask positions
// ****************************************************
`define FSM_UV             0
`define FSM_OV             1
`define FSM_OT             2
`define FSM_SC             3
`define FSM_W              4
`define FSM_RESET          4'hf

`endif

// *** verilog/hbridge_pkg.sv ***
// Types shared by the bridge output and fault supervision modules.
`include "hbridge_defines.svh"

package hbridge_pkg;

    // ****************************************************
    // Filtered fault channels
    // ****************************************************
    typedef enum {
        CH_TW,
        CH_OT,
        CH_UV,
        CH_OV,
        CH_SCA,
        CH_SCB,
        CH_OC,
        CH_NUM
    } fault_ch_t;

    typedef logic [`CLR_W-1:0] clr_bits_t;
    typedef logic [`FSM_W-1:0] fs_mask_t;

    // Filter length in cycles for each channel
    function automatic int filter_cycles(input int ch);
        int cyc;
        cyc = `OC_FILTER_CYC;
        case (ch)
            CH_TW:   cyc = `TW_FILTER_CYC;
            CH_OT:   cyc = `OT_FILTER_CYC;
            CH_UV:   cyc = `UV_FILTER_CYC;
            CH_OV:   cyc = `OV_FILTER_CYC;
            CH_SCA:  cyc = `SC_FILTER_CYC;
            CH_SCB:  cyc = `SC_FILTER_CYC;
            default: cyc = `OC_FILTER_CYC;
        endcase
        if (cyc < 1) begin
            cyc = 1;
        end
        return cyc;
    endfunction : filter_cycles

endpackage : hbridge_pkg

// *** verilog/fault_filter_if.sv ***
// Raw and filtered fault conditions passed between the supervisor and its filter bank.
`timescale 1ns/10ps

interface fault_filter_if #(
    parameter int NCH = 7
);
    logic [NCH-1:0] raw;   // Live comparator conditions
    logic [NCH-1:0] hit;   // Conditions that persisted for the full filter time

    modport supervisor (output raw, input hit);
    modport filter (input raw, output hit);
endinterface : fault_filter_if

// *** verilog/fault_filter_bank.sv ***
// Bank of persistence counters that qualify each raw fault condition.
`timescale 1ns/10ps

module fault_filter_bank
    import hbridge_pkg::*;
#(
    parameter int NCH   = 7,
    parameter int CNT_W = 8
) (
    input  wire logic          clk_sys_i,
    input  wire logic          rst_i,
    fault_filter_if.filter     flt
);

    // ****************************************************
    // One counter per channel
    // ****************************************************
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            localparam logic [CNT_W-1:0] LIMIT = CNT_W'(filter_cycles(g));
            logic [CNT_W-1:0] cnt_ff;   // Cycles the condition has persisted
            logic             hit_ff;   // Qualified condition

            // Count while the condition holds; any drop restarts the wait
            always_ff @(posedge clk_sys_i) begin
                if (rst_i) begin
                    cnt_ff <= '0;
                end else if (!flt.raw[g]) begin
                    cnt_ff <= '0;
                end else if (cnt_ff < LIMIT) begin
                    cnt_ff <= cnt_ff + CNT_W'(1);
                end
            end

            // Hit rises at full count, falls as soon as the condition goes
            always_ff @(posedge clk_sys_i) begin
                if (rst_i) begin
                    hit_ff <= 1'b0;
                end else begin
                    hit_ff <= flt.raw[g] && (cnt_ff >= LIMIT - CNT_W'(1));
                end
            end

            assign flt.hit[g] = hit_ff;
        end
    endgenerate

endmodule : fault_filter_bank

// *** verilog/hbridge_output_fault_logic.sv ***
// Output control and fault supervision for an H-bridge or dual half-bridge driver.
//
// What this block does
// - Temperature warning never shuts outputs down.
// - Warning flag is live and self-clearing.
// - Filtered overtemperature latches outputs off, sets flag.
// - Kill toggle, enable toggle, or clear resets latches.
// - Drive needs enable high, kill low, allow set.
// - Source select swaps virtual inputs for pins.
// - Undervoltage tri-states outputs, pulls fault status low.
// - Undervoltage recovery restores outputs; status stays low.
// - H-bridge overvoltage forces both outputs high.
// - Overvoltage recovery follows inputs; status stays low.
// - Half-bridge overvoltage leaves outputs unchanged.
// - Short or overtemperature latches outputs tri-state.
// - H-bridge short disables both outputs together.
// - Half-bridge short disables only the faulted output.
// - H-bridge floating inputs give reverse or freewheel.
// - Mask bits choose which faults pull status.
// - Overtemperature flag clears only by its clear bit.
// - Warning detection active except in sleep.
// - Overcurrent only sets a latched flag.
// - Open-load check on normal entry or request, H-bridge only.
// - Half-bridge: each input drives its own output.
// - H-bridge: A direction, B PWM, low freewheels high.
`timescale 1ns/10ps
`include "hbridge_defines.svh"

module hbridge_output_fault_logic
    import hbridge_pkg::*;
(
    input  wire logic                  clk_sys_i,
    input  wire logic                  rst_i,
    input  wire logic                  chip_enable_in_i,
    input  wire logic                  output_kill_in_i,
    input  wire logic                  drive_input_a_i,
    input  wire logic                  drive_input_a_float_i,
    input  wire logic                  drive_input_b_i,
    input  wire logic                  drive_input_b_float_i,
    input  wire logic                  drive_allow_i,
    input  wire logic                  hbridge_mode_i,
    input  wire logic                  virtual_select_i,
    input  wire logic                  virtual_input_a_i,
    input  wire logic                  virtual_input_b_i,
    input  wire hbridge_pkg::fs_mask_t fs_mask_i,
    input  wire logic                  clear_fault_i,
    input  wire hbridge_pkg::clr_bits_t clear_bits_i,
    input  wire logic                  open_load_check_en_i,
    input  wire logic                  open_load_req_i,
    input  wire logic                  open_load_raw_i,
    input  wire logic                  temp_warn_raw_i,
    input  wire logic                  overtemp_raw_i,
    input  wire logic                  undervolt_raw_i,
    input  wire logic                  overvolt_raw_i,
    input  wire logic                  short_a_raw_i,
    input  wire logic                  short_b_raw_i,
    input  wire logic                  overcurrent_raw_i,
    output logic                       bridge_out_a_o,
    output logic                       bridge_out_a_oe_o,
    output logic                       bridge_out_b_o,
    output logic                       bridge_out_b_oe_o,
    output logic                       fault_status_n_o,
    output logic                       open_load_check_o,
    output logic                       temp_warning_flag_o,
    output logic                       overtemp_fault_flag_o,
    output logic                       overcurrent_flag_o,
    output logic                       open_load_flag_o,
    output logic                       undervolt_flag_o,
    output logic                       overvolt_flag_o,
    output logic                       short_a_flag_o,
    output logic                       short_b_flag_o
);

    import hbridge_pkg::*;

    // ****************************************************
    // Fault filters
    // ****************************************************
    localparam int NCH = CH_NUM;

    fault_filter_if #(.NCH(NCH)) flt ();   // Raw in, qualified out

    fault_filter_bank #(
        .NCH   (NCH),
        .CNT_W (8)
    ) u_filters (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .flt       (flt.filter)
    );

    logic sleep;        // Chip enable low or floating
    logic tw_hit;       // Qualified temperature warning
    logic ot_hit;       // Qualified overtemperature
    logic uv_hit;       // Qualified undervoltage
    logic ov_hit;       // Qualified overvoltage
    logic sca_hit;      // Qualified short on output A
    logic scb_hit;      // Qualified short on output B
    logic oc_hit;       // Qualified overcurrent

    assign sleep = !chip_enable_in_i;

    // Pack raw conditions; supervision that needs normal mode is gated by sleep
    always_comb begin
        flt.raw         = '0;
        flt.raw[CH_TW]  = temp_warn_raw_i && !sleep;
        flt.raw[CH_OT]  = overtemp_raw_i && !sleep;
        flt.raw[CH_UV]  = undervolt_raw_i && !sleep;
        flt.raw[CH_OV]  = overvolt_raw_i && !sleep;
        flt.raw[CH_SCA] = short_a_raw_i && !sleep;
        flt.raw[CH_SCB] = short_b_raw_i && !sleep;
        flt.raw[CH_OC]  = overcurrent_raw_i && !sleep;
    end

    assign tw_hit  = flt.hit[CH_TW];
    assign ot_hit  = flt.hit[CH_OT];
    assign uv_hit  = flt.hit[CH_UV];
    assign ov_hit  = flt.hit[CH_OV];
    assign sca_hit = flt.hit[CH_SCA];
    assign scb_hit = flt.hit[CH_SCB];
    assign oc_hit  = flt.hit[CH_OC];

    // ****************************************************
    // Reset events for latched output states
    // ****************************************************
    logic kill_d_ff;     // Kill pin one cycle ago
    logic enable_d_ff;   // Enable pin one cycle ago
    logic drive_on_d_ff; // Drive permission one cycle ago
    logic pin_reset;     // Kill released or enable raised
    logic clr;           // Clear-fault strobe
    logic drive_on;      // Device allowed to drive at all

    // Edge history of the control pins
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            kill_d_ff     <= 1'b0;
            enable_d_ff   <= 1'b0;
            drive_on_d_ff <= 1'b0;
        end else begin
            kill_d_ff     <= output_kill_in_i;
            enable_d_ff   <= chip_enable_in_i;
            drive_on_d_ff <= drive_on;
        end
    end

    assign drive_on  = chip_enable_in_i && !output_kill_in_i && drive_allow_i;
    // A full toggle ends on the release edge, so that edge clears the latches
    assign pin_reset = (kill_d_ff && !output_kill_in_i)
                    || (!enable_d_ff && chip_enable_in_i);
    assign clr       = clear_fault_i;

    // ****************************************************
    // Latched output shutdowns
    // ****************************************************
    logic ot_off_ff;     // Outputs latched off by overtemperature
    logic sca_off_ff;    // Output A latched off by a short
    logic scb_off_ff;    // Output B latched off by a short
    logic any_sc;

    assign any_sc = sca_hit || scb_hit;

    // Overtemperature shutdown; a new hit wins over a clear in the same cycle
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ot_off_ff <= 1'b0;
        end else if (ot_hit) begin
            ot_off_ff <= 1'b1;
        end else if (pin_reset || clr) begin
            ot_off_ff <= 1'b0;
        end
    end

    // Short shutdowns: joint in H-bridge, per output in half-bridge
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sca_off_ff <= 1'b0;
            scb_off_ff <= 1'b0;
        end else if (hbridge_mode_i && any_sc) begin
            sca_off_ff <= 1'b1;
            scb_off_ff <= 1'b1;
        end else begin
            if (sca_hit) begin
                sca_off_ff <= 1'b1;
            end else if (pin_reset || clr) begin
                sca_off_ff <= 1'b0;
            end
            if (scb_hit) begin
                scb_off_ff <= 1'b1;
            end else if (pin_reset || clr) begin
                scb_off_ff <= 1'b0;
            end
        end
    end

    // ****************************************************
    // Input selection and decoding
    // ****************************************************
    logic in_a;          // Selected direction or A input
    logic in_b;          // Selected PWM or B input
    logic a_float;       // Physical A disconnected
    logic b_float;       // Physical B disconnected
    logic dec_a;         // Decoded level for output A
    logic dec_b;         // Decoded level for output B

    // Virtual inputs displace the pins, and floating only applies to the pins
    always_comb begin
        in_a    = virtual_select_i ? virtual_input_a_i : drive_input_a_i;
        in_b    = virtual_select_i ? virtual_input_b_i : drive_input_b_i;
        a_float = !virtual_select_i && drive_input_a_float_i;
        b_float = !virtual_select_i && drive_input_b_float_i;
        if (b_float) begin
            in_b = 1'b0;
        end
    end

    // Truth-table decode for both topologies
    always_comb begin
        dec_a = 1'b0;
        dec_b = 1'b0;
        if (!hbridge_mode_i) begin
            dec_a = a_float ? 1'b0 : in_a;
            dec_b = in_b;
        end else if (a_float) begin
            dec_a = !in_b;
            dec_b = 1'b1;
        end else if (!in_b) begin
            dec_a = 1'b1;
            dec_b = 1'b1;
        end else begin
            dec_a = in_a;
            dec_b = !in_a;
        end
        // Overvoltage braking in H-bridge only; half-bridge keeps its decode
        if (hbridge_mode_i && ov_hit) begin
            dec_a = 1'b1;
            dec_b = 1'b1;
        end
    end

    // ****************************************************
    // Output stage
    // ****************************************************
    logic common_ok;     // No condition that idles both outputs

    // Warning is deliberately absent here: it must never stop the bridge
    assign common_ok = drive_on && !uv_hit && !ot_off_ff;

    // Registered drive levels and enables
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            bridge_out_a_o    <= 1'b0;
            bridge_out_b_o    <= 1'b0;
            bridge_out_a_oe_o <= 1'b0;
            bridge_out_b_oe_o <= 1'b0;
        end else begin
            bridge_out_a_o    <= dec_a;
            bridge_out_b_o    <= dec_b;
            bridge_out_a_oe_o <= common_ok && !sca_off_ff;
            bridge_out_b_oe_o <= common_ok && !scb_off_ff;
        end
    end

    // ****************************************************
    // Fault status pin
    // ****************************************************
    logic fs_set;        // Masked fault that pulls status low
    logic fs_latch_ff;   // Status latched low until reset event

    assign fs_set = (fs_mask_i[`FSM_UV] && uv_hit)
                 || (fs_mask_i[`FSM_OV] && ov_hit)
                 || (fs_mask_i[`FSM_OT] && ot_hit)
                 || (fs_mask_i[`FSM_SC] && any_sc);

    // Latched low indication; a fresh fault wins over a reset event
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            fs_latch_ff <= 1'b0;
        end else if (fs_set) begin
            fs_latch_ff <= 1'b1;
        end else if (pin_reset || clr) begin
            fs_latch_ff <= 1'b0;
        end
    end

    // Sleep reads high, kill or allow low reads low, otherwise the latch decides
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            fault_status_n_o <= 1'b1;
        end else if (sleep) begin
            fault_status_n_o <= 1'b1;
        end else if (output_kill_in_i || !drive_allow_i) begin
            fault_status_n_o <= 1'b0;
        end else begin
            fault_status_n_o <= !(fs_latch_ff || fs_set);
        end
    end

    // ****************************************************
    // Status flags
    // ****************************************************
    // Live warning, no memory, so a read always sees the present state
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            temp_warning_flag_o <= 1'b0;
        end else begin
            temp_warning_flag_o <= tw_hit;
        end
    end

    // Latched flags: each clears only through its own clear bit, set wins
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            overtemp_fault_flag_o <= 1'b0;
            overcurrent_flag_o    <= 1'b0;
            undervolt_flag_o      <= 1'b0;
            overvolt_flag_o       <= 1'b0;
            short_a_flag_o        <= 1'b0;
            short_b_flag_o        <= 1'b0;
        end else begin
            // Clearing while still hot keeps the flag set
            overtemp_fault_flag_o <= ot_hit
                || (overtemp_fault_flag_o && !(clr && clear_bits_i[`CLR_OT]));
            overcurrent_flag_o    <= oc_hit
                || (overcurrent_flag_o && !(clr && clear_bits_i[`CLR_OC]));
            undervolt_flag_o      <= uv_hit
                || (undervolt_flag_o && !(clr && clear_bits_i[`CLR_UV]));
            overvolt_flag_o       <= ov_hit
                || (overvolt_flag_o && !(clr && clear_bits_i[`CLR_OV]));
            short_a_flag_o        <= sca_hit
                || (short_a_flag_o && !(clr && clear_bits_i[`CLR_SCA]));
            short_b_flag_o        <= scb_hit
                || (short_b_flag_o && !(clr && clear_bits_i[`CLR_SCB]));
        end
    end

    // ****************************************************
    // Open-load check
    // ****************************************************
    logic ol_start;      // Entry to drive or host request

    // Only meaningful across a full bridge, so half-bridge never starts it
    assign ol_start = hbridge_mode_i && open_load_check_en_i
                   && ((drive_on && !drive_on_d_ff) || open_load_req_i);

    // One-cycle check strobe; the comparator is sampled while it stands
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            open_load_check_o <= 1'b0;
        end else begin
            open_load_check_o <= ol_start;
        end
    end

    // Information only: the flag never touches the outputs
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            open_load_flag_o <= 1'b0;
        end else begin
            open_load_flag_o <= (open_load_check_o && open_load_raw_i)
                || (open_load_flag_o && !(clr && clear_bits_i[`CLR_OL]));
        end
    end

endmodule : hbridge_output_fault_logic

// *** tb/hbridge_fault_monitor.sv ***
// Port checks for the bridge output and fault supervision block.
`timescale 1ns/10ps

module hbridge_fault_monitor (
    input wire logic clk_sys_i, rst_i, chip_enable_in_i, output_kill_in_i,
    input wire logic hbridge_mode_i, temp_warn_raw_i, overtemp_raw_i,
    input wire logic bridge_out_a_o, bridge_out_b_o, bridge_out_a_oe_o,
    input wire logic bridge_out_b_oe_o, fault_status_n_o, temp_warning_flag_o,
    input wire logic overtemp_fault_flag_o, undervolt_flag_o, overvolt_flag_o,
    input wire logic short_a_flag_o
);
    import hbridge_pkg::*;
    logic [7:0] ot_run_ff; // Awake cycles of raw overtemp; saturates so it never wraps
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || !overtemp_raw_i || !chip_enable_in_i) ot_run_ff <= 8'h00;
        else if (ot_run_ff != 8'hff) ot_run_ff <= ot_run_ff + 8'h01;
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    a_sleep_high: assert property (!chip_enable_in_i |=> fault_status_n_o)
        else $error("sleep status low");
    a_kill_low: assert property (output_kill_in_i && chip_enable_in_i |=> !fault_status_n_o)
        else $error("kill status high");
    a_warn_live: assert property (!temp_warn_raw_i [*4] |-> !temp_warning_flag_o)
        else $error("warning stuck");
    a_ot_latch: assert property (ot_run_ff > 8'd111 |-> !bridge_out_a_oe_o)
        else $error("overtemp late");
    a_ot_filter: assert property ($rose(overtemp_fault_flag_o) |-> ot_run_ff > 8'd109)
        else $error("overtemp early");
    a_uv_off: assert property ($rose(undervolt_flag_o) |-> !bridge_out_b_oe_o)
        else $error("undervolt drives");
    a_ov_high: assert property (
        $rose(overvolt_flag_o) && hbridge_mode_i |-> bridge_out_a_o && bridge_out_b_o)
        else $error("overvolt not high");
    a_short_both: assert property (
        $rose(short_a_flag_o) && hbridge_mode_i |=> !bridge_out_b_oe_o)
        else $error("short left b on");
    c_ot: cover property ($rose(overtemp_fault_flag_o));
    c_ov: cover property ($rose(overvolt_flag_o) && hbridge_mode_i);
    c_sc: cover property ($rose(short_a_flag_o) && !hbridge_mode_i);
endmodule : hbridge_fault_monitor

bind hbridge_output_fault_logic hbridge_fault_monitor u_mon (.*);

// *** tb/host_clear_model.sv ***
// Host model that issues clear-fault strobes to the bridge block.
`timescale 1ns/10ps

module host_clear_model (
    input  wire logic              clk_sys_i,     // System clock
    output logic                   clear_fault_o, // One-cycle clear strobe
    output hbridge_pkg::clr_bits_t clear_bits_o   // Flags cleared with it
);
    import hbridge_pkg::*;
    initial begin
        clear_fault_o = 1'b0;
        clear_bits_o = 8'h00;
    end
    // Only called once the condition is gone, since a clear under a live fault is ignored
    task automatic clr(clr_bits_t b);
        @(posedge clk_sys_i);
        clear_fault_o <= 1'b1;
        clear_bits_o <= b;
        @(posedge clk_sys_i);
        clear_fault_o <= 1'b0;
        clear_bits_o <= ~b;    // Idle field carries junk, not the last value
    endtask : clr
endmodule : host_clear_model

// *** tb/testbench.sv ***
// Self-checking bench for the bridge output and fault supervision block.
`timescale 1ns/10ps

module testbench;
    import hbridge_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic en = 1'b0, kill = 1'b0, allow = 1'b0, hb = 1'b0, vs = 1'b0;
    logic ia = 1'b0, ib = 1'b0, fa = 1'b0, fb = 1'b0, va = 1'b0, vb = 1'b0;
    logic olen = 1'b0, olreq = 1'b0, olraw = 1'b0;
    logic cf, oa, ob, oea, oeb, fsn, olc, olf;
    logic [6:0] raw = 7'h00, flg; // Order: warn, ot, uv, ov, short a, short b, oc
    fs_mask_t mask = 4'hf;
    clr_bits_t cb;
    int fail_count = 0, checks_done = 0;

    initial forever #50 clk_sys_i = ~clk_sys_i;

    host_clear_model u_host (.clk_sys_i, .clear_fault_o(cf), .clear_bits_o(cb));
    hbridge_output_fault_logic u_dut (.clk_sys_i, .rst_i, .chip_enable_in_i(en),
        .output_kill_in_i(kill), .drive_input_a_i(ia), .drive_input_a_float_i(fa),
        .drive_input_b_i(ib), .drive_input_b_float_i(fb), .drive_allow_i(allow),
        .hbridge_mode_i(hb), .virtual_select_i(vs), .virtual_input_a_i(va),
        .virtual_input_b_i(vb), .fs_mask_i(mask), .clear_fault_i(cf), .clear_bits_i(cb),
        .open_load_check_en_i(olen), .open_load_req_i(olreq), .open_load_raw_i(olraw),
        .temp_warn_raw_i(raw[0]), .overtemp_raw_i(raw[1]), .undervolt_raw_i(raw[2]),
        .overvolt_raw_i(raw[3]), .short_a_raw_i(raw[4]), .short_b_raw_i(raw[5]),
        .overcurrent_raw_i(raw[6]), .bridge_out_a_o(oa), .bridge_out_a_oe_o(oea),
        .bridge_out_b_o(ob), .bridge_out_b_oe_o(oeb), .fault_status_n_o(fsn),
        .open_load_check_o(olc), .temp_warning_flag_o(flg[0]), .overtemp_fault_flag_o(flg[1]),
        .overcurrent_flag_o(flg[6]), .open_load_flag_o(olf), .undervolt_flag_o(flg[2]),
        .overvolt_flag_o(flg[3]), .short_a_flag_o(flg[4]), .short_b_flag_o(flg[5]));

    task automatic chk(logic [3:0] got, logic [3:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic nx(int n);
        repeat (n) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
    endtask : nx

    task automatic print_verdict();
        if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    // Bridge levels from {mode, b float, a float, b, a}; a floating input reads low
    function automatic logic [1:0] dec(logic [4:0] k);
        logic a, b;
        a = k[0] & ~k[2];
        b = k[1] & ~k[3];
        if (!k[4]) return {a, b};
        if (k[2]) return {~b, 1'b1};
        return b ? {k[0], ~k[0]} : 2'b11;
    endfunction : dec

    // Hold one condition past its filter, drop it, then clear through the host
    task automatic flt(int i, logic [7:0] e, logic [1:0] o);
        @(posedge clk_sys_i) raw <= 7'h01 << i;
        nx(115);
        chk({oea, oeb, fsn, flg[i]}, e[7:4]);
        if (i == 3) chk({2'b00, oa, ob}, {2'b00, o});
        @(posedge clk_sys_i) raw <= 7'h00;
        nx(3);
        chk({oea, oeb, fsn, flg[i]}, e[3:0]);
        u_host.clr(8'h7f);
        nx(3);
        chk({oea, oeb, fsn, flg[i]}, 4'he);
    endtask : flt

    initial begin
        logic [4:0] k;
        repeat (5) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        en <= 1'b1;
        allow <= 1'b1;
        // Pins inverted while virtual inputs are selected, so a wrong source shows
        for (int i = 0; i < 64; i++) begin
            @(posedge clk_sys_i) {vs, hb, fb, fa} <= i[5:2];
            ia <= i[0] ^ i[5];
            ib <= i[1] ^ i[5];
            va <= i[0];
            vb <= i[1];
            k = {i[4], i[3:2] & {2{~i[5]}}, i[1:0]};
            nx(1);
            chk({oea, oeb, oa, ob}, {2'b11, dec(k)});
        end
        @(posedge clk_sys_i) {vs, hb, fb, fa, ib, ia} <= 6'h13;
        flt(0, 8'hfe, 2'b00);
        flt(1, 8'h11, 2'b00);
        flt(2, 8'h1d, 2'b00);
        flt(3, 8'hdd, 2'b11);
        flt(4, 8'h11, 2'b00);
        flt(6, 8'hff, 2'b00);
        // Requested open-load check: strobe stands one cycle, flag latches after it
        @(posedge clk_sys_i) {olen, olreq, olraw} <= 3'h7;
        @(posedge clk_sys_i) olreq <= 1'b0;
        nx(0);
        chk({olc, olf, 2'b00}, 4'h8);
        nx(1);
        chk({olc, olf, 2'b00}, 4'h4);
        u_host.clr(8'h04);
        nx(1);
        chk({olc, olf, 2'b00}, 4'h0);
        @(posedge clk_sys_i) mask <= 4'h0;
        flt(2, 8'h3f, 2'b00);
        @(posedge clk_sys_i) {mask, hb, ib} <= 6'h3c;
        flt(3, 8'hdd, 2'b10);
        flt(4, 8'h55, 2'b00);
        flt(5, 8'h99, 2'b00);
        // Kill toggle after a short frees the output latch but keeps the flag
        @(posedge clk_sys_i) raw <= 7'h10;
        nx(12);
        @(posedge clk_sys_i) {raw, kill} <= 8'h01;
        @(posedge clk_sys_i) kill <= 1'b0;
        nx(2);
        chk({oea, oeb, fsn, flg[4]}, 4'hf);
        u_host.clr(8'h20);
        // Half-bridge refuses a requested open-load check
        @(posedge clk_sys_i) olreq <= 1'b1;
        @(posedge clk_sys_i) olreq <= 1'b0;
        nx(0);
        chk({olc, olf, 2'b00}, 4'h0);
        @(posedge clk_sys_i) allow <= 1'b0;
        nx(1);
        chk({oea, oeb, fsn, 1'b0}, 4'h0);
        @(posedge clk_sys_i) {allow, kill} <= 2'b11;
        nx(1);
        chk({oea, oeb, fsn, 1'b0}, 4'h0);
        @(posedge clk_sys_i) en <= 1'b0;
        nx(2);
        chk({oea, oeb, fsn, 1'b0}, 4'h2);
        print_verdict();
    end

    // Whole run needs about 1420 cycles
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        fail_count++;
        print_verdict();
    end
endmodule : testbench
